// file: uraf_defines.svh
// register offsets, field positions and reset values of the receive address filter
`ifndef URAF_DEFINES_SVH
`define URAF_DEFINES_SVH

`define URAF_ADR_W          5
`define URAF_ADR_CTRL       5'h00
`define URAF_ADR_RXBUF      5'h04
`define URAF_ADR_PWR        5'h08
`define URAF_ADR_SLADR      5'h0C
`define URAF_ADR_SMASK      5'h10

`define URAF_CTL_BIT7       7
`define URAF_CTL_MODE_LO    6
`define URAF_CTL_MPE        5
`define URAF_CTL_REN        4
`define URAF_CTL_TX9        3
`define URAF_CTL_RX9        2
`define URAF_CTL_TXF        1
`define URAF_CTL_RXF        0
`define URAF_PWR_FESEL      6

`define URAF_CTRL_RST       8'h00
`define URAF_ADDR_RST       8'h00
`define URAF_CNT_W          4
`define URAF_SMP_A          4'h7
`define URAF_SMP_B          4'h8
`define URAF_SMP_C          4'h9
`define URAF_LAST_IDX_8BIT  4'h9
`define URAF_LAST_IDX_9BIT  4'hA
`define URAF_NINTH_IDX      4'h9

`endif

// file: uraf_pkg.sv
// types shared by the receive address filter modules
`default_nettype none
package uraf_pkg;

    typedef enum logic [1:0] {
        URAF_MODE_SHIFT,
        URAF_MODE_8BIT_VAR,
        URAF_MODE_9BIT_FIX,
        URAF_MODE_9BIT_VAR
    } uraf_mode_t;

    typedef enum logic {
        URAF_ST_IDLE,
        URAF_ST_FRAME
    } uraf_state_t;

endpackage : uraf_pkg

`default_nettype wire

// file: uraf_match_if.sv
// carrier between the receiver and its address comparator
`timescale 1ns/1ps
`default_nettype none

interface uraf_match_if;
    logic [7:0] rx_byte;
    logic [7:0] addr;
    logic [7:0] mask;
    logic       hit;

    modport req (output rx_byte, output addr, output mask, input hit);
    modport cmp (input rx_byte, input addr, input mask, output hit);
endinterface : uraf_match_if

`default_nettype wire

// file: uraf_addr_match.sv
// given and broadcast address comparator
`timescale 1ns/1ps
`default_nettype none

module uraf_addr_match
    import uraf_pkg::*;
(
    uraf_match_if.cmp m
);
    logic [7:0] bcast;
    logic       given_hit;
    logic       bcast_hit;

    always_comb
    begin
        given_hit = (((m.rx_byte ^ m.addr) & m.mask) == 8'h00);
        bcast     = m.addr | m.mask;
        bcast_hit = ((m.rx_byte & bcast) == bcast);
        m.hit     = given_hit | bcast_hit;
    end
endmodule : uraf_addr_match

`default_nettype wire

// file: uraf_rx.sv
// serial receiver with multiprocessor filter and address recognition, wishbone slave
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "uraf_defines.svh"

module uraf_rx
    import uraf_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [`URAF_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   rxd_i,
    input  wire logic                   baud_tick16_i,
    output logic                        receive_flag_o
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser: stage one feeds stage two only
    logic rxd_meta_q;
    logic rxd_sync_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rxd_meta_q <= 1'b1;
            rxd_sync_q <= 1'b1;
        end
        else
        begin
            rxd_meta_q <= rxd_i;
            rxd_sync_q <= rxd_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0]  ctrl_q, ctrl_d;
    logic        fe_q, fe_d;
    logic        fe_sel_q, fe_sel_d;
    logic [7:0]  rx_buffer_q, rx_buffer_d;
    logic [7:0]  sladr_q, sladr_d;
    logic [7:0]  smask_q, smask_d;
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;

    // receiver state
    uraf_state_t           state_q, state_d;
    logic [`URAF_CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0]            idx_q, idx_d;
    logic                  smp_a_q, smp_a_d;
    logic                  smp_b_q, smp_b_d;
    logic                  rx_last_q, rx_last_d;
    logic [7:0]            data_q, data_d;
    logic                  ninth_q, ninth_d;

    logic       wr;
    logic       wr_ctrl;
    logic       vote;
    logic       start_seen;
    logic       final_pulse;
    logic       accept;
    logic       bad_stop;
    logic [3:0] last_idx;
    logic       nine_bit;
    uraf_mode_t mode;

    uraf_match_if mif ();

    uraf_addr_match u_match (
        .m (mif)
    );

    assign mif.rx_byte = data_q;
    assign mif.addr    = sladr_q;
    assign mif.mask    = smask_q;

    ////////////////////////////////////////////////////////////////////////////
    // receive engine
    always_comb
    begin
        mode       = uraf_mode_t'({ctrl_q[`URAF_CTL_BIT7], ctrl_q[`URAF_CTL_MODE_LO]});
        nine_bit   = mode[1];
        last_idx   = nine_bit ? `URAF_LAST_IDX_9BIT : `URAF_LAST_IDX_8BIT;
        vote       = (smp_a_q & smp_b_q) | (smp_a_q & rxd_sync_q) | (smp_b_q & rxd_sync_q);
        state_d    = state_q;
        cnt_d      = cnt_q;
        idx_d      = idx_q;
        smp_a_d    = smp_a_q;
        smp_b_d    = smp_b_q;
        data_d     = data_q;
        ninth_d    = ninth_q;
        rx_last_d  = baud_tick16_i ? rxd_sync_q : rx_last_q;
        start_seen = 1'b0;
        final_pulse = 1'b0;
        bad_stop   = 1'b0;
        accept     = 1'b0;
        case (state_q)
            URAF_ST_IDLE:
            begin
                // shift mode never enters here, so the multiprocessor bit has no say in it
                if (baud_tick16_i && ctrl_q[`URAF_CTL_REN] && mode != URAF_MODE_SHIFT
                    && rx_last_q && !rxd_sync_q)
                begin
                    start_seen = 1'b1;
                    state_d    = URAF_ST_FRAME;
                    cnt_d      = '0;
                    idx_d      = 4'h0;
                end
            end
            URAF_ST_FRAME:
            begin
                if (!ctrl_q[`URAF_CTL_REN])
                begin
                    state_d = URAF_ST_IDLE;
                end
                else if (baud_tick16_i)
                begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `URAF_SMP_A)
                    begin
                        smp_a_d = rxd_sync_q;
                    end
                    if (cnt_q == `URAF_SMP_B)
                    begin
                        smp_b_d = rxd_sync_q;
                    end
                    if (cnt_q == `URAF_SMP_C)
                    begin
                        idx_d = idx_q + 4'h1;
                        if (idx_q == 4'h0 && vote)
                        begin
                            state_d = URAF_ST_IDLE;
                        end
                        else if (idx_q == last_idx)
                        begin
                            final_pulse = 1'b1;
                            bad_stop    = !vote;
                            accept      = !ctrl_q[`URAF_CTL_RXF] && (!ctrl_q[`URAF_CTL_MPE]
                                          || (nine_bit ? (ninth_q && mif.hit) : vote));
                            state_d     = URAF_ST_IDLE;
                        end
                        else if (idx_q == `URAF_NINTH_IDX)
                        begin
                            ninth_d = vote;
                        end
                        else if (idx_q != 4'h0)
                        begin
                            data_d = {vote, data_q[7:1]};
                        end
                    end
                end
            end
            default:
            begin
                state_d = URAF_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q   <= URAF_ST_IDLE;
            cnt_q     <= '0;
            idx_q     <= 4'h0;
            smp_a_q   <= 1'b1;
            smp_b_q   <= 1'b1;
            rx_last_q <= 1'b1;
            data_q    <= 8'h00;
            ninth_q   <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            idx_q     <= idx_d;
            smp_a_q   <= smp_a_d;
            smp_b_q   <= smp_b_d;
            rx_last_q <= rx_last_d;
            data_q    <= data_d;
            ninth_q   <= ninth_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the strobe, write lands on the ack edge
    always_comb
    begin
        ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
        wr      = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
        wr_ctrl = wr && wb_adr_i == `URAF_ADR_CTRL;
        ctrl_d  = ctrl_q;
        fe_d    = fe_q;
        fe_sel_d    = fe_sel_q;
        rx_buffer_d = rx_buffer_q;
        sladr_d = sladr_q;
        smask_d = smask_q;
        if (wr_ctrl)
        begin
            // bit 7 lands in whichever store the select bit points at
            ctrl_d[6:0] = wb_dat_i[6:0];
            if (fe_sel_q)
            begin
                fe_d = wb_dat_i[`URAF_CTL_BIT7];
            end
            else
            begin
                ctrl_d[`URAF_CTL_BIT7] = wb_dat_i[`URAF_CTL_BIT7];
            end
        end
        if (wr && wb_adr_i == `URAF_ADR_PWR)
        begin
            fe_sel_d = wb_dat_i[`URAF_PWR_FESEL];
        end
        if (wr && wb_adr_i == `URAF_ADR_SLADR)
        begin
            sladr_d = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == `URAF_ADR_SMASK)
        begin
            smask_d = wb_dat_i[7:0];
        end
        // hardware sets win over a software clear in the same cycle
        if (bad_stop)
        begin
            fe_d = 1'b1;
        end
        if (accept)
        begin
            rx_buffer_d            = data_q;
            // eight-bit mode keeps the voted stop bit, even a bad one when the filter is off
            ctrl_d[`URAF_CTL_RX9]  = nine_bit ? ninth_q : vote;
            ctrl_d[`URAF_CTL_RXF]  = 1'b1;
        end
        rdata_d = 32'h0000_0000;
        if (ack_d)
        begin
            case (wb_adr_i)
                `URAF_ADR_CTRL:
                begin
                    rdata_d[7:0] = {fe_sel_q ? fe_q : ctrl_q[`URAF_CTL_BIT7], ctrl_q[6:0]};
                end
                `URAF_ADR_RXBUF:
                begin
                    rdata_d[7:0] = rx_buffer_q;
                end
                `URAF_ADR_PWR:
                begin
                    rdata_d[`URAF_PWR_FESEL] = fe_sel_q;
                end
                `URAF_ADR_SLADR:
                begin
                    rdata_d[7:0] = sladr_q;
                end
                `URAF_ADR_SMASK:
                begin
                    rdata_d[7:0] = smask_q;
                end
                default:
                begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_q      <= `URAF_CTRL_RST;
            fe_q        <= 1'b0;
            fe_sel_q    <= 1'b0;
            rx_buffer_q <= 8'h00;
            sladr_q     <= `URAF_ADDR_RST;
            smask_q     <= `URAF_ADDR_RST;
            ack_q       <= 1'b0;
            rdata_q     <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            fe_q        <= fe_d;
            fe_sel_q    <= fe_sel_d;
            rx_buffer_q <= rx_buffer_d;
            sladr_q     <= sladr_d;
            smask_q     <= smask_d;
            ack_q       <= ack_d;
            rdata_q     <= rdata_d;
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = rdata_q;
    assign receive_flag_o = ctrl_q[`URAF_CTL_RXF];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_sample_point;
        state_q == URAF_ST_FRAME && ctrl_q[`URAF_CTL_REN] && baud_tick16_i && cnt_q == `URAF_SMP_C;
    endsequence

    sequence seq_false_start;
        seq_sample_point ##0 (idx_q == 4'h0 && vote);
    endsequence

    chk_false_start: assert property (seq_false_start |=> state_q == URAF_ST_IDLE)
        else $error("false start did not return to idle");

    chk_edge_align: assert property (start_seen |=> state_q == URAF_ST_FRAME && cnt_q == 4'h0)
        else $error("start edge did not reset bit counter");

    chk_flag_no_clear: assert property ($fell(ctrl_q[`URAF_CTL_RXF]) |-> $past(wr_ctrl))
        else $error("receive flag cleared without software write");

    chk_load_flag_low: assert property (accept |-> !ctrl_q[`URAF_CTL_RXF])
        else $error("frame loaded while receive flag set");

    chk_fe_sticky: assert property (fe_q && !wr_ctrl |=> fe_q)
        else $error("framing error cleared by hardware");

    chk_mp_filter: assert property (accept && nine_bit && ctrl_q[`URAF_CTL_MPE]
                                    |-> ninth_q && mif.hit)
        else $error("filtered frame accepted without address");

    chk_buffer_load: assert property (accept |=> rx_buffer_q == $past(data_q)
                                      && ctrl_q[`URAF_CTL_RXF])
        else $error("accepted frame not loaded");

    chk_reject_keep: assert property (final_pulse && !accept |=> $stable(rx_buffer_q))
        else $error("rejected frame altered the buffer");

    chk_idle_no_ren: assert property (!ctrl_q[`URAF_CTL_REN] && state_q == URAF_ST_IDLE
                                      |=> state_q == URAF_ST_IDLE)
        else $error("receiver started while disabled");

    chk_addr_reset: assert property ($fell(sys_rst) |-> sladr_q == 8'h00 && smask_q == 8'h00)
        else $error("address registers not cleared by reset");

    chk_bit7_read: assert property (ack_d && !wb_we_i && wb_adr_i == `URAF_ADR_CTRL
                                    |=> wb_dat_o[7] == ($past(fe_sel_q) ? $past(fe_q)
                                                                       : $past(ctrl_q[7])))
        else $error("bit 7 read from wrong store");

endmodule : uraf_rx

`default_nettype wire

// file: uraf_serial_node.sv
// far-side serial node: sends one asynchronous frame per request
`timescale 1ns/1ps
`default_nettype none

module uraf_serial_node (
    input  wire logic        clk,
    input  wire logic        baud_tick16_i,
    input  wire logic        go,
    input  wire logic [11:0] frame_bits,
    input  wire logic [3:0]  n_bits,
    input  wire logic [4:0]  first_len,
    output var  logic        line_o,
    output var  logic        busy_o
);
    logic [11:0] sh;
    int          left;
    int          tk;

    // line idles high between frames, like a pulled-up multidrop wire
    initial
    begin
        line_o = 1'b1;
        busy_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bits go out lsb first, sixteen ticks each; a short first bit fakes a glitch
    always @(posedge clk)
    begin
        if (!busy_o)
        begin
            if (go)
            begin
                busy_o <= 1'b1;
                sh     <= frame_bits;
                left   <= n_bits;
                tk     <= first_len;
                line_o <= frame_bits[0];
            end
        end
        else if (baud_tick16_i)
        begin
            if (tk > 1)
                tk <= tk - 1;
            else if (left > 1)
            begin
                sh     <= sh >> 1;
                line_o <= sh[1];
                left   <= left - 1;
                tk     <= 16;
            end
            else
            begin
                busy_o <= 1'b0;
                line_o <= 1'b1;
            end
        end
    end
endmodule : uraf_serial_node

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the receive address filter
`timescale 1ns/1ps
`default_nettype none
`include "uraf_defines.svh"

module tb_top;
    logic        clk   = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic        tick  = 1'b0;
    logic        go    = 1'b0;
    logic [4:0]  adr   = 5'h00;
    logic [3:0]  sel   = 4'h1;
    logic [31:0] wdat  = 32'h0000_0000;
    logic [11:0] fbits = 12'h0FFF;
    logic [3:0]  nbits = 4'h1;
    logic [4:0]  flen  = 5'h10;
    logic [1:0]  tdiv  = 2'h0;
    wire  logic [31:0] rdat;
    wire  logic  ack;
    wire  logic  rxd;
    wire  logic  flag;
    wire  logic  busy;
    int n_errors    = 0;
    int checks_done = 0;
    int m_mh, m_ml, m_mpe, m_ren, m_fesel, m_fe, m_b2, m_flag, m_buf, m_sa, m_sm;
    int seed, ml, k;
    int tb_d[6] = '{8'hC2, 8'hC2, 8'hC1, 8'hFF, 8'hC0, 8'h5D};
    int tb_n[6] = '{0, 1, 1, 1, 1, 1};

    always #12.5 clk = ~clk;

    // one-cycle oversampling enable every fourth clock keeps frames short
    always @(posedge clk)
    begin
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
    end

    uraf_rx dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rxd_i(rxd), .baud_tick16_i(tick), .receive_flag_o(flag));

    uraf_serial_node node (.clk(clk), .baud_tick16_i(tick), .go(go), .frame_bits(fbits),
        .n_bits(nbits), .first_len(flen), .line_o(rxd), .busy_o(busy));

    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // classic cycle: hold everything until ack is sampled, release after it
    task wb(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h00_0000, d};
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (ack !== 1'b1 && i < 20);
        r = rdat;
        if (ack !== 1'b1)
        begin
            n_errors++;
            wrap_up();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 8'h00, r);
        chk(r, e);
    endtask : rd

    function logic [31:0] ctl_exp();
        return {24'h00_0000, m_fesel[0] ? m_fe[0] : m_mh[0], m_ml[0], m_mpe[0], m_ren[0],
                1'b0, m_b2[0], 1'b0, m_flag[0]};
    endfunction : ctl_exp

    // every control write also clears the receive flag
    task cw(input int mh, input int mlo, input int mpe, input int ren);
        logic [31:0] r;
        wb(1'b1, `URAF_ADR_CTRL, {mh[0], mlo[0], mpe[0], ren[0], 1'b0, m_b2[0], 2'b00}, r);
        if (m_fesel != 0)
            m_fe = mh;
        else
            m_mh = mh;
        m_ml = mlo;
        m_mpe = mpe;
        m_ren = ren;
        m_flag = 0;
    endtask : cw

    task wreg(input logic [4:0] a, input int d);
        logic [31:0] r;
        wb(1'b1, a, d[7:0], r);
        if (a == `URAF_ADR_SLADR)
            m_sa = d;
        if (a == `URAF_ADR_SMASK)
            m_sm = d;
        if (a == `URAF_ADR_PWR)
            m_fesel = d[6];
    endtask : wreg

    function int hit(input int b);
        return (((b ^ m_sa) & m_sm) == 0) || (((~b) & (m_sa | m_sm) & 255) == 0);
    endfunction : hit

    task wait_busy(input logic v);
        int i;
        i = 0;
        while (busy !== v && i < 3000)
        begin
            @(posedge clk);
            i++;
        end
        if (i == 3000)
        begin
            n_errors++;
            wrap_up();
        end
    endtask : wait_busy

    task send(input int d, input int nin, input int stop, input int gl);
        int mode, acc, live;
        mode = m_mh * 2 + m_ml;
        fbits <= (mode >= 2) ? {1'b1, stop[0], nin[0], d[7:0], 1'b0} : {2'b11, stop[0], d[7:0], 1'b0};
        nbits <= gl ? 4'h1 : ((mode >= 2) ? 4'hB : 4'hA);
        flen  <= gl ? 5'h03 : 5'h10;
        live = (gl == 0) && (m_ren != 0) && (mode != 0);
        acc = live && (m_flag == 0) && ((mode == 1) ? (!m_mpe || stop) : (!m_mpe || (nin && hit(d))));
        if (live && stop == 0)
            m_fe = 1;
        if (acc)
        begin
            m_buf = d & 255;
            m_b2 = (mode == 1) ? stop : nin;
            m_flag = 1;
        end
        go <= 1'b1;
        wait_busy(1'b1);
        go <= 1'b0;
        wait_busy(1'b0);
        repeat (4) @(posedge clk);
        chk({31'h0, flag}, m_flag);
        rd(`URAF_ADR_CTRL, ctl_exp());
        rd(`URAF_ADR_RXBUF, m_buf);
    endtask : send

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = $urandom(48);
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(`URAF_ADR_CTRL, 32'h0000_0000);
        rd(`URAF_ADR_SLADR, 32'h0000_0000);
        rd(`URAF_ADR_SMASK, 32'h0000_0000);
        wreg(5'h14, 8'hAA);
        rd(5'h14, 32'h0000_0000);
        cw(0, 1, 0, 1);
        repeat (3)
        begin
            send($urandom % 256, 0, 1, 0);
            cw(0, 1, 0, 1);
        end
        send(8'h5A, 0, 1, 0);
        send(8'hA5, 0, 1, 0);
        cw(0, 1, 0, 1);
        send(0, 0, 1, 1);
        send(8'h96, 0, 0, 0);
        cw(0, 1, 1, 1);
        send(8'h3C, 0, 0, 0);
        wreg(`URAF_ADR_PWR, 8'h40);
        rd(`URAF_ADR_CTRL, ctl_exp());
        send(8'hC3, 0, 1, 0);
        cw(0, 1, 1, 1);
        rd(`URAF_ADR_CTRL, ctl_exp());
        wreg(`URAF_ADR_PWR, 8'h00);
        cw(0, 0, 1, 1);
        send(8'h11, 0, 1, 0);
        cw(0, 1, 0, 0);
        send(8'h22, 0, 1, 0);
        for (ml = 0; ml < 2; ml++)
        begin
            cw(1, ml, 0, 1);
            send($urandom % 256, 0, 1, 0);
            wreg(`URAF_ADR_SLADR, ml ? 8'hE0 : 8'hC0);
            wreg(`URAF_ADR_SMASK, ml ? 8'hFA : 8'hFD);
            rd(`URAF_ADR_SMASK, m_sm);
            for (k = 0; k < 6; k++)
            begin
                cw(1, ml, 1, 1);
                send(k == 5 ? $urandom % 256 : tb_d[k], tb_n[k], 1, 0);
            end
        end
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
